// ### verilog/bank1_sfr_pkg.sv
// constants for the upper-bank special function register file
package bank1_sfr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address on the bus is four times these)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INDIRECT_DATA_PORT = 8'h80;
  localparam logic [7:0] IDX_PRESCALER_EDGE_CFG = 8'h81;
  localparam logic [7:0] IDX_PC_LOW_BYTE        = 8'h82;
  localparam logic [7:0] IDX_CORE_FLAGS         = 8'h83;
  localparam logic [7:0] IDX_INDIRECT_POINTER   = 8'h84;
  localparam logic [7:0] IDX_PORT_A_DIRECTION   = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION   = 8'h86;
  localparam logic [7:0] IDX_PC_HIGH_LATCH      = 8'h8a;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL  = 8'h8b;
  localparam logic [7:0] IDX_PERIPH_IRQ_ENABLE  = 8'h8c;
  localparam logic [7:0] IDX_RESET_CAUSE_FLAGS  = 8'h8e;
  localparam logic [7:0] IDX_ANALOG_PIN_CONFIG  = 8'h9f;
  localparam logic [7:0] IDX_BANK_FIRST         = 8'h80;
  localparam logic [7:0] IDX_BANK_LAST          = 8'h9f;
  localparam logic [7:0] IDX_EVENT_STATUS       = 8'ha0;
  localparam logic [7:0] IDX_EVENT_CLEAR        = 8'ha1;
  localparam logic [7:0] IDX_EVENT_ENABLE       = 8'ha2;
  localparam logic [7:0] IDX_BANK1_BIT          = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLAG_TIMEOUT       = 4;
  localparam int FLAG_POWER_DOWN    = 3;
  localparam int INTERRUPT_CONTROL_GLOBAL      = 7;
  localparam int INTERRUPT_CONTROL_PERIPH      = 6;
  localparam int CONVERTER_DONE_BIT = 6;
  localparam int CAUSE_PARITY_EN    = 7;
  localparam int CAUSE_PARITY_RST   = 2;
  localparam int CAUSE_POWER_ON     = 1;
  localparam int CAUSE_BROWN_OUT    = 0;
  localparam int EVT_WIDTH          = 3;
  localparam int EVT_PERIPH         = 0;
  localparam int EVT_WATCHDOG       = 1;
  localparam int EVT_MASTER_CLEAR   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRESCALER_EDGE_CFG = 8'hff;
  localparam logic [5:0] RST_PORT_A_DIRECTION   = 6'h3f;
  localparam logic [7:0] RST_PORT_B_DIRECTION   = 8'hff;
  localparam logic [7:0] RST_CORE_FLAGS_POWER   = 8'h18;
  localparam logic [7:0] RST_ZERO_BYTE          = 8'h00;

endpackage : bank1_sfr_pkg

// ### verilog/bank1_special_register_file.sv
// upper-bank special function register file with apb slave port
`timescale 1ns/100ps
`default_nettype none

// Operation
// - indirect port accesses memory at pointer address
// - pc latch loads upper pc on update
// - shared registers decode in both banks
// - unimplemented locations and bits read zero
// - converter-done enable at bit six, resets zero
// - group enable gates every peripheral interrupt
// - master clear, watchdog load alternate values
// - unchanged bits kept, per set, bor cleared by brown-out, por kept
module bank1_special_register_file
  import bank1_sfr_pkg::*;
#(
  parameter int MEM_DEPTH = 256
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset causes, one-cycle pulses
  input  wire logic        master_clear_reset,
  input  wire logic        watchdog_reset,
  input  wire logic        brownout_reset,
  // peripheral and strap inputs
  input  wire logic        converter_done,
  input  wire logic        parity_enable,
  // configuration towards the core
  output logic      [7:0]  prescaler_config,
  output logic      [12:0] program_counter,
  output logic      [7:0]  core_flags,
  output logic      [5:0]  port_a_dir,
  output logic      [7:0]  port_b_dir,
  output logic      [1:0]  analog_config,
  // interrupts
  output logic             core_interrupt,
  output logic             irq
);

  // memory address width; the pointer is cut down to it
  localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the pointer holds 8 bits, so a deeper memory could never be reached,
  // and a depth off a power of two would alias unevenly
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("MEM_DEPTH must be a power of two from 2 to 256");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0]                option;
    logic [7:0]                pc_low;
    logic [4:0]                pc_high;
    logic [7:0]                flags;
    logic [7:0]                pointer;
    logic [5:0]                tris_a;
    logic [7:0]                tris_b;
    logic [4:0]                pc_high_latch;
    logic [7:0]                interrupt_control;
    logic                      converter_done_enable;
    logic                      per;
    logic                      por;
    logic                      bor;
    logic [1:0]                adcon;
    logic [EVT_WIDTH-1:0]      evt_status;
    logic [EVT_WIDTH-1:0]      evt_enable;
    logic                      periph_prev;
    logic [31:0]               rdata;
    logic                      slverr;
    logic                      core_int;
    logic                      irq;
  } state_t;

  // values loaded by the reset pin, a power-up reset
  localparam state_t RESET_STATE = '{
    mem:         '0,
    option:      RST_PRESCALER_EDGE_CFG,
    pc_low:      RST_ZERO_BYTE,
    pc_high:     5'h00,
    flags:       RST_CORE_FLAGS_POWER,
    pointer:     RST_ZERO_BYTE,
    tris_a:      RST_PORT_A_DIRECTION,
    tris_b:      RST_PORT_B_DIRECTION,
    pc_high_latch:      5'h00,
    interrupt_control:      RST_ZERO_BYTE,
    converter_done_enable:        1'b0,
    per:         1'b1,
    por:         1'b0,
    bor:         1'b1,
    adcon:       2'h0,
    evt_status:  '0,
    evt_enable:  '0,
    periph_prev: 1'b0,
    rdata:       32'h0000_0000,
    slverr:      1'b0,
    core_int:    1'b0,
    irq:         1'b0
  };

  // registered state and its next value
  state_t s_reg;
  state_t s_next;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // word index to register index; shared registers answer in bank 0 too
  function automatic logic [8:0] map_index(input logic [11:0] addr);
    logic [7:0] idx;
    logic [7:0] up;
    logic       hit;
    idx = addr[9:2];
    up  = idx | IDX_BANK1_BIT;
    hit = 1'b0;
    // above the first kilobyte nothing answers
    if (addr[11:10] == 2'b00)
    begin
      if (idx >= IDX_BANK_FIRST && idx <= IDX_BANK_LAST)
        hit = 1'b1;
      else if (idx == IDX_EVENT_STATUS || idx == IDX_EVENT_CLEAR || idx == IDX_EVENT_ENABLE)
        hit = 1'b1;
      // in bank 0 only the shared registers answer
      else if (idx < IDX_BANK1_BIT &&
               (up == IDX_INDIRECT_DATA_PORT || up == IDX_PC_LOW_BYTE ||
                up == IDX_CORE_FLAGS || up == IDX_INDIRECT_POINTER ||
                up == IDX_PC_HIGH_LATCH || up == IDX_INTERRUPT_CONTROL))
      begin
        hit = 1'b1;
        idx = up;
      end
    end
    return {hit, idx};
  endfunction : map_index

  // loads the values of a reset; power selects the power-up class
  function automatic state_t apply_reset(input state_t s, input logic power,
                                         input logic wdog);
    state_t r;
    // fields not named here keep their value, as unchanged bits must
    r        = s;
    r.option = RST_PRESCALER_EDGE_CFG;
    r.pc_low = RST_ZERO_BYTE;
    r.pc_high = 5'h00;
    r.tris_a = RST_PORT_A_DIRECTION;
    r.tris_b = RST_PORT_B_DIRECTION;
    r.pc_high_latch = 5'h00;
    r.converter_done_enable   = 1'b0;
    r.adcon  = 2'h0;
    r.per    = 1'b1;
    r.flags[7:5]  = 3'b000;
    r.interrupt_control[7:1] = 7'h00;
    if (power)
    begin
      r.flags   = RST_CORE_FLAGS_POWER;
      r.pointer = RST_ZERO_BYTE;
      r.interrupt_control  = RST_ZERO_BYTE;
      r.bor     = 1'b0;
    end
    else if (wdog)
    begin
      // alternate class: pointer, low flags, bit 0 of interrupt_control, por and bor kept, per set
      r.flags[FLAG_TIMEOUT]    = 1'b0;
      r.flags[FLAG_POWER_DOWN] = 1'b1;
    end
    return r;
  endfunction : apply_reset

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // hit flag and register index of the current address
  logic [8:0] map;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic [AW-1:0] mem_addr;

  assign map      = map_index(paddr);
  assign hit      = map[8];
  assign idx      = map[7:0];
  assign mem_addr = s_reg.pointer[AW-1:0];

  // selects the byte of the addressed register, zero elsewhere
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_INDIRECT_DATA_PORT: rd_byte = s_reg.mem[mem_addr];
      IDX_PRESCALER_EDGE_CFG: rd_byte = s_reg.option;
      IDX_PC_LOW_BYTE:        rd_byte = s_reg.pc_low;
      IDX_CORE_FLAGS:         rd_byte = s_reg.flags;
      IDX_INDIRECT_POINTER:   rd_byte = s_reg.pointer;
      IDX_PORT_A_DIRECTION:   rd_byte = {2'b00, s_reg.tris_a};
      IDX_PORT_B_DIRECTION:   rd_byte = s_reg.tris_b;
      IDX_PC_HIGH_LATCH:      rd_byte = {3'b000, s_reg.pc_high_latch};
      IDX_INTERRUPT_CONTROL:  rd_byte = s_reg.interrupt_control;
      IDX_PERIPH_IRQ_ENABLE:  rd_byte = {1'b0, s_reg.converter_done_enable, 6'h00};
      IDX_RESET_CAUSE_FLAGS:  rd_byte = {parity_enable, 4'h0, s_reg.per, s_reg.por, s_reg.bor};
      IDX_ANALOG_PIN_CONFIG:  rd_byte = {6'h00, s_reg.adcon};
      IDX_EVENT_STATUS:       rd_byte = {5'h00, s_reg.evt_status};
      IDX_EVENT_ENABLE:       rd_byte = {5'h00, s_reg.evt_enable};
      default:                rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // bus phase decode and interrupt helpers
  logic                 setup;
  logic                 wr;
  logic                 periph_req;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [7:0]           ic;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;

  // peripheral request needs its own enable and the group enable
  assign periph_req = s_reg.interrupt_control[INTERRUPT_CONTROL_PERIPH] & s_reg.converter_done_enable & converter_done;

  always_comb
  begin
    s_next  = s_reg;
    evt_set = '0;
    ic      = s_reg.interrupt_control;
    // a held converter request raises its event once, on its rise
    evt_set[EVT_PERIPH]       = periph_req & ~s_reg.periph_prev;
    evt_set[EVT_WATCHDOG]     = watchdog_reset;
    evt_set[EVT_MASTER_CLEAR] = master_clear_reset;
    s_next.periph_prev        = periph_req;

    // read data and error are captured in the setup cycle
    if (setup)
    begin
      // a refused read returns zero, not a register of another window
      s_next.rdata  = (pwrite || !hit) ? 32'h0000_0000 : {24'h000000, rd_byte};
      s_next.slverr = ~hit;
    end

    // register writes; unmapped addresses and bits are dropped
    if (wr && hit)
    begin
      unique case (idx)
        IDX_INDIRECT_DATA_PORT: s_next.mem[mem_addr] = pwdata[7:0];
        IDX_PRESCALER_EDGE_CFG: s_next.option = pwdata[7:0];
        IDX_PC_LOW_BYTE:
        begin
          s_next.pc_low  = pwdata[7:0];
          s_next.pc_high = s_reg.pc_high_latch;
        end
        IDX_CORE_FLAGS:
        begin
          // timeout and power-down are read-only
          s_next.flags[7:5] = pwdata[7:5];
          s_next.flags[2:0] = pwdata[2:0];
        end
        IDX_INDIRECT_POINTER:   s_next.pointer = pwdata[7:0];
        IDX_PORT_A_DIRECTION:   s_next.tris_a = pwdata[5:0];
        IDX_PORT_B_DIRECTION:   s_next.tris_b = pwdata[7:0];
        IDX_PC_HIGH_LATCH:      s_next.pc_high_latch = pwdata[4:0];
        IDX_INTERRUPT_CONTROL:  s_next.interrupt_control = pwdata[7:0];
        IDX_PERIPH_IRQ_ENABLE:  s_next.converter_done_enable = pwdata[CONVERTER_DONE_BIT];
        IDX_RESET_CAUSE_FLAGS:
        begin
          s_next.per = pwdata[CAUSE_PARITY_RST];
          s_next.por = pwdata[CAUSE_POWER_ON];
          s_next.bor = pwdata[CAUSE_BROWN_OUT];
        end
        IDX_ANALOG_PIN_CONFIG:  s_next.adcon = pwdata[1:0];
        IDX_EVENT_CLEAR:        s_next.evt_status = s_reg.evt_status & ~pwdata[EVT_WIDTH-1:0];
        IDX_EVENT_ENABLE:       s_next.evt_enable = pwdata[EVT_WIDTH-1:0];
        default:                s_next.evt_enable = s_reg.evt_enable;
      endcase
    end

    // resets of the core override the bus
    if (brownout_reset)
      s_next = apply_reset(s_next, 1'b1, 1'b0);
    else if (watchdog_reset || master_clear_reset)
      s_next = apply_reset(s_next, 1'b0, watchdog_reset);

    // events win over a clear in the same cycle
    s_next.evt_status = s_next.evt_status | evt_set;
    s_next.irq        = |(s_next.evt_status & s_next.evt_enable);

    // core interrupt: global enable over all enabled sources
    // the other sources pair an enable with its flag in the same register
    ic = s_next.interrupt_control;
    s_next.core_int = ic[INTERRUPT_CONTROL_GLOBAL] &
                      ((ic[INTERRUPT_CONTROL_PERIPH] & s_next.converter_done_enable & converter_done) |
                       (ic[5] & ic[2]) | (ic[4] & ic[1]) | (ic[3] & ic[0]));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one register stage for all state
  // the reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave; data and error come from flops
  assign pready           = 1'b1;
  assign prdata           = s_reg.rdata;
  assign pslverr          = s_reg.slverr;
  // configuration towards the core comes straight from flops
  assign prescaler_config = s_reg.option;
  assign program_counter  = {s_reg.pc_high, s_reg.pc_low};
  assign core_flags       = s_reg.flags;
  assign port_a_dir       = s_reg.tris_a;
  assign port_b_dir       = s_reg.tris_b;
  assign analog_config    = s_reg.adcon;
  assign core_interrupt   = s_reg.core_int;
  assign irq              = s_reg.irq;

endmodule : bank1_special_register_file

`default_nettype wire

// ### tb/bank1_sfr_chk.sv
// assertion checker for the upper-bank register file
`timescale 1ns/100ps
`default_nettype none
module bank1_sfr_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // reset causes
  input wire logic        master_clear_reset,
  input wire logic        watchdog_reset,
  input wire logic        brownout_reset,
  // outputs
  input wire logic [7:0]  prescaler_config,
  input wire logic [12:0] program_counter,
  input wire logic [7:0]  core_flags,
  input wire logic [5:0]  port_a_dir,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic       acc;
  logic       nores;
  logic       unimpl;
  assign idx = paddr[9:2];
  assign acc = psel && penable && (paddr[11:10] == 2'h0);
  assign nores = !master_clear_reset && !watchdog_reset && !brownout_reset;
  assign unimpl = (idx inside {8'h87, 8'h88, 8'h89, 8'h8d}) || (idx > 8'h8e && idx < 8'h9f);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_pcl;
    acc && pwrite && nores && (idx == 8'h82 || idx == 8'h02)
      |=> program_counter[7:0] == $past(pwdata[7:0]);
  endproperty
  a_pcl: assert property (p_pcl) else $error("pc low byte not loaded");
  property p_pchold;
    !(psel && penable && pwrite) && nores |=> $stable(program_counter);
  endproperty
  a_pchold: assert property (p_pchold) else $error("pc moved");
  property p_mirror;
    acc && (idx inside {8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b}) |-> !pslverr;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror refused");
  property p_unimpl;
    acc && !pwrite && unimpl |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("hole not zero");
  property p_hi;
    psel && penable |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_wdt;
    watchdog_reset && !brownout_reset |=> core_flags[4:3] == 2'h1
      && prescaler_config == 8'hff && program_counter == 13'h0;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog values");
  property p_bor;
    brownout_reset |=> core_flags[4:3] == 2'h3 && port_a_dir == 6'h3f;
  endproperty
  a_bor: assert property (p_bor) else $error("brownout values");
  property p_master_clear_pin;
    master_clear_reset && !watchdog_reset && !brownout_reset
      |=> core_flags[4:3] == $past(core_flags[4:3]) && program_counter == 13'h0;
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear values");
  // main scenarios
  c_wdt: cover property (watchdog_reset);
  c_err: cover property (psel && penable && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : bank1_sfr_chk

bind bank1_special_register_file bank1_sfr_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .master_clear_reset(master_clear_reset), .watchdog_reset(watchdog_reset),
  .brownout_reset(brownout_reset), .prescaler_config(prescaler_config),
  .program_counter(program_counter), .core_flags(core_flags),
  .port_a_dir(port_a_dir), .irq(irq));
`default_nettype wire

// ### tb/bank1_special_register_file_test.sv
// self-checking testbench for the upper-bank register file
`timescale 1ns/100ps
`default_nettype none
module bank1_special_register_file_test
  import bank1_sfr_pkg::*;
;
  // fields: write flag, index, write data, expected read
  typedef struct packed {logic [3:0] w; logic [7:0] i, d, e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, core_interrupt, irq;
  logic [7:0] prescaler_config, core_flags, port_b_dir;
  logic [12:0] program_counter;
  logic [5:0] port_a_dir;
  logic [1:0] analog_config;
  logic master_clear_reset = 0, watchdog_reset = 0, brownout_reset = 0;
  logic converter_done = 0, parity_enable = 1;
  int fail_count = 0, n_tests = 0, cycles = 0;
  row_t rows [$] = '{28'h08100ff, 28'h0820000, 28'h0830018, 28'h0840000,
    28'h085003f, 28'h08600ff, 28'h08a0000, 28'h08b0000, 28'h08c0000, 28'h08e0085,
    28'h09f0000, 28'h0870000, 28'h08d0000, 28'h09e0000, 28'h0a10000, 28'h1810000,
    28'h0810000, 28'h185ff00, 28'h085003f, 28'h18cff00, 28'h08c0040, 28'h19fff00,
    28'h09f0003, 28'h187ff00, 28'h0870000, 28'h1841000, 28'h180a500, 28'h1841100,
    28'h1803c00, 28'h1041000, 28'h08000a5, 28'h0840010, 28'h1841100, 28'h080003c,
    28'h1830700, 28'h003001f, 28'h18a1500, 28'h1823400, 28'h00a0015, 28'h10b4000,
    28'h08b0040};

  bank1_special_register_file dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_reset(master_clear_reset), .watchdog_reset(watchdog_reset),
    .brownout_reset(brownout_reset), .converter_done(converter_done),
    .parity_enable(parity_enable), .prescaler_config(prescaler_config),
    .program_counter(program_counter), .core_flags(core_flags),
    .port_a_dir(port_a_dir), .port_b_dir(port_b_dir), .analog_config(analog_config),
    .core_interrupt(core_interrupt), .irq(irq));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(r, {24'h0, e});
  endtask : rd
  task automatic pulse(input logic [2:0] m);
    @(posedge pclk);
    {brownout_reset, watchdog_reset, master_clear_reset} <= m;
    @(posedge pclk);
    {brownout_reset, watchdog_reset, master_clear_reset} <= 3'h0;
    #1;
  endtask : pulse
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k])
    begin
      apb(rows[k].w[0], rows[k].i, rows[k].d);
      if (rows[k].w[0] == 1'b0) chk(r, {24'h0, rows[k].e});
    end
    #1 chk(program_counter, 13'h1534);
    chk(port_a_dir, 6'h3f);
    chk(analog_config, 2'h3);
    chk(core_flags, 8'h1f);
    chk(prescaler_config, 8'h00);
    chk(port_b_dir, RST_PORT_B_DIRECTION);
    chk(pready, 1'b1);
    // group enable gates the converter request
    apb(1'b1, 8'h8b, 8'h80);
    converter_done <= 1'b1;
    settle();
    chk(core_interrupt, 1'b0);
    apb(1'b1, 8'h8b, 8'hc0);
    settle();
    chk(core_interrupt, 1'b1);
    // power-up class, then master clear, then watchdog
    apb(1'b1, 8'ha2, 8'h06);
    pulse(3'h4);
    rd(8'h8e, 8'h84);
    apb(1'b0, 8'h83, 8'h00);
    chk(r & 32'h18, 32'h18);
    settle();
    chk(core_interrupt, 1'b0);
    pulse(3'h1);
    chk(irq, 1'b1);
    apb(1'b0, 8'h83, 8'h00);
    chk(r & 32'h18, 32'h18);
    rd(8'ha0, 8'h05);
    apb(1'b1, 8'ha1, 8'h04);
    settle();
    chk(irq, 1'b0);
    rd(8'ha0, 8'h01);
    apb(1'b1, 8'h83, 8'h07);
    apb(1'b1, 8'h84, 8'h22);
    apb(1'b1, 8'h81, 8'h00);
    pulse(3'h2);
    chk(irq, 1'b1);
    rd(8'h83, 8'h0f);
    chk(core_flags, 8'h0f);
    chk(program_counter, 13'h0000);
    chk(prescaler_config, 8'hff);
    rd(8'h84, 8'h22);
    rd(8'h81, RST_PRESCALER_EDGE_CFG);
    rd(8'h8c, 8'h00);
    rd(8'h8e, 8'h84);
    rd(8'ha0, 8'h03);
    apb(1'b1, 8'ha2, 8'h00);
    settle();
    chk(irq, 1'b0);
    // unmapped place refuses and reads zero
    apb(1'b1, 8'h01, 8'h55);
    chk(err, 1'b1);
    apb(1'b0, 8'h01, 8'h00);
    chk(err, 1'b1);
    chk(r, 32'h0000_0000);
    // second power-up reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h83, RST_CORE_FLAGS_POWER);
    rd(8'h8e, 8'h85);
    rd(8'h8c, 8'h00);
    chk(program_counter, 13'h0000);
    chk(port_a_dir, RST_PORT_A_DIRECTION);
    chk(irq, 1'b0);
    stop_test();
  end
endmodule : bank1_special_register_file_test
`default_nettype wire
